// >>> occ_osc_clock_config.v
/*
 * Oscillator clock configuration registers behind a classic Wishbone
 * slave: 32 kHz source select, bandgap sleep behaviour, sleep interval,
 * CPU clock divider, system clock range and the write-once crystal
 * configuration.
 * Assumes the clock input is the system clock, rstn is asserted on
 * every power-on or external pin reset, and the 32 kHz oscillator
 * levels arrive from outside this clock domain.
 */
`default_nettype none
`include "occ_consts.vh"

module occ_osc_clock_config (
    input wire clock,
    input wire rstn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`OCC_ADR_W-1:0] wb_adr_i,
    input wire [`OCC_SEL_W-1:0] wb_sel_i,
    input wire [`OCC_DAT_W-1:0] wb_dat_i,
    output reg [`OCC_DAT_W-1:0] wb_dat_o,
    output reg wb_ack_o,
    input wire osc_int_32k,
    input wire osc_ext_32k,
    output reg clk_32k,
    output reg ext_32k_select,
    output reg bandgap_keep_on,
    output reg bandgap_buzz_disable,
    output reg [1:0] sleep_interval,
    output wire cpu_clock_tick,
    output reg crystal_low_power,
    output reg crystal_present,
    output reg [1:0] system_clock_range,
    output reg system_clock_external
);

    // ************************************************************
    // Register state
    // ************************************************************
    reg [`OCC_REG_W-1:0] osc_ctrl0;
    reg xtal_low_power;
    reg xtal_present;
    reg xtal_written;
    reg [`OCC_REG_W-1:0] system_clock_cfg;

    // ************************************************************
    // Wishbone decode
    // ************************************************************
    wire take;
    wire aligned;
    wire [`OCC_IDX_W-1:0] index;
    wire lane0;
    wire wr;
    wire hit_ctrl0;
    wire hit_xtal;
    wire hit_system_clock;
    wire hit_status;

    // Accept one request per ack; the cycle with ack high blocks reuse
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign aligned = (wb_adr_i[`OCC_IDX_LSB-1:0] == 2'h0);
    assign index = wb_adr_i[`OCC_ADR_W-1:`OCC_IDX_LSB];
    assign lane0 = wb_sel_i[0];
    assign wr = take & wb_we_i & lane0;
    assign hit_ctrl0 = aligned & (index == `OCC_IDX_OSC_CTRL0);
    assign hit_xtal = aligned & (index == `OCC_IDX_XTAL_CFG);
    assign hit_system_clock = aligned & (index == `OCC_IDX_SYSTEM_CLOCK_CFG);
    assign hit_status = aligned & (index == `OCC_IDX_STATUS);

    // ************************************************************
    // Derived state
    // ************************************************************
    wire want_ext;
    wire next_ext_select;
    wire next_buzz_disable;
    wire [`OCC_REG_W-1:0] xtal_read;
    wire [`OCC_REG_W-1:0] status_read;
    wire [1:0] osc_sync;

    assign want_ext = osc_ctrl0[`OCC_F_EXT_32K_SELECT];
    // Crystal is reachable only once software declared it present
    assign next_ext_select = want_ext & xtal_present;
    // Keep-on wins; the disable bit acts only while buzzing
    assign next_buzz_disable = osc_ctrl0[`OCC_F_BUZZ_DISABLE] &
                               ~osc_ctrl0[`OCC_F_BANDGAP_KEEP];

    assign xtal_read = {5'h00, xtal_low_power, xtal_written,
                        xtal_present};
    assign status_read = {5'h00, want_ext & ~xtal_present,
                          xtal_written, ext_32k_select};

    // ************************************************************
    // Bus answer
    // ************************************************************
    reg [`OCC_REG_W-1:0] rdata;

    // Unmapped or misaligned addresses read zero and still ack
    always @* begin
        rdata = 8'h00;
        if (hit_ctrl0) begin
            rdata = osc_ctrl0;
        end else if (hit_xtal) begin
            rdata = xtal_read;
        end else if (hit_system_clock) begin
            rdata = system_clock_cfg;
        end else if (hit_status) begin
            rdata = status_read;
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= {`OCC_DAT_W{1'b0}};
        end else begin
            wb_ack_o <= take;
            if (take) begin
                wb_dat_o <= {24'h000000, rdata};
            end
        end
    end

    // ************************************************************
    // oscillator_control_zero
    // ************************************************************
    // All eight bits are fields, so the written byte is stored unmasked
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            osc_ctrl0 <= `OCC_RST_OSC_CTRL0;
        end else if (wr & hit_ctrl0) begin
            osc_ctrl0 <= wb_dat_i[`OCC_REG_W-1:0];
        end
    end

    // ************************************************************
    // crystal_oscillator_config, write once per reset
    // ************************************************************
    // Only rstn can reopen the lock, so no software path clears it
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            xtal_low_power <= 1'b0;
            xtal_present <= 1'b0;
            xtal_written <= 1'b0;
        end else if (wr & hit_xtal & ~xtal_written) begin
            xtal_low_power <= wb_dat_i[`OCC_F_CRYSTAL_LOW_POWER];
            xtal_present <= wb_dat_i[`OCC_F_CRYSTAL_PRESENT];
            xtal_written <= 1'b1;
        end
    end

    // ************************************************************
    // System clock configuration
    // ************************************************************
    // Range code 3 is not a valid setting and falls back to 12 MHz
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            system_clock_cfg <= `OCC_RST_SYSTEM_CLOCK_CFG;
        end else if (wr & hit_system_clock) begin
            system_clock_cfg <= {5'h00, wb_dat_i[`OCC_F_SYSTEM_CLOCK_EXT:0]};
        end
    end

    // ************************************************************
    // Registered control outputs
    // ************************************************************
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ext_32k_select <= 1'b0;
            bandgap_keep_on <= 1'b0;
            bandgap_buzz_disable <= 1'b0;
            sleep_interval <= 2'h0;
            crystal_low_power <= 1'b0;
            crystal_present <= 1'b0;
            system_clock_range <= `OCC_SYSTEM_CLOCK_12M;
            system_clock_external <= 1'b0;
        end else begin
            ext_32k_select <= next_ext_select;
            bandgap_keep_on <= osc_ctrl0[`OCC_F_BANDGAP_KEEP];
            bandgap_buzz_disable <= next_buzz_disable;
            sleep_interval <=
                osc_ctrl0[`OCC_F_SLEEP_HI:`OCC_F_SLEEP_LO];
            crystal_low_power <= xtal_low_power;
            crystal_present <= xtal_present;
            if (system_clock_cfg[`OCC_F_SYSTEM_CLOCK_RANGE_HI:`OCC_F_SYSTEM_CLOCK_RANGE_LO]
                == 2'h3) begin
                system_clock_range <= `OCC_SYSTEM_CLOCK_12M;
            end else begin
                system_clock_range <= system_clock_cfg[`OCC_F_SYSTEM_CLOCK_RANGE_HI:
                                           `OCC_F_SYSTEM_CLOCK_RANGE_LO];
            end
            system_clock_external <= system_clock_cfg[`OCC_F_SYSTEM_CLOCK_EXT];
        end
    end

    // ************************************************************
    // 32 kHz source multiplexer
    // ************************************************************
    // The 32K clock is resampled on the system clock; edges carry up to
    // one system period of jitter, harmless at 32 kHz
    occ_sync2 u_sync (
        .clock(clock),
        .rstn(rstn),
        .async_in({osc_ext_32k, osc_int_32k}),
        .sync_out(osc_sync)
    );

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clk_32k <= 1'b0;
        end else if (ext_32k_select) begin
            clk_32k <= osc_sync[1];
        end else begin
            clk_32k <= osc_sync[0];
        end
    end

    // ************************************************************
    // CPU clock divider
    // ************************************************************
    occ_cpu_div u_div (
        .clock(clock),
        .rstn(rstn),
        .code(osc_ctrl0[`OCC_F_CPU_DIV_HI:`OCC_F_CPU_DIV_LO]),
        .tick(cpu_clock_tick)
    );

endmodule // occ_osc_clock_config

`default_nettype wire

// >>> occ_consts.vh
/*
 * Constants for the oscillator clock configuration block: register
 * indices, field positions, reset values and CPU divider reload values.
 * Assumes it is included by bare name from every design file that
 * needs it; it holds definitions only.
 */
`ifndef OCC_CONSTS_VH
`define OCC_CONSTS_VH

// ************************************************************
// Bus geometry
// ************************************************************
`define OCC_ADR_W 10
`define OCC_IDX_W 8
`define OCC_IDX_LSB 2
`define OCC_DAT_W 32
`define OCC_SEL_W 4
`define OCC_REG_W 8

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define OCC_IDX_OSC_CTRL0 8'hE0
`define OCC_IDX_XTAL_CFG 8'hE1
`define OCC_IDX_SYSTEM_CLOCK_CFG 8'hF0
`define OCC_IDX_STATUS 8'hF1

// ************************************************************
// oscillator_control_zero fields
// ************************************************************
`define OCC_F_EXT_32K_SELECT 7
`define OCC_F_BUZZ_DISABLE 6
`define OCC_F_BANDGAP_KEEP 5
`define OCC_F_SLEEP_HI 4
`define OCC_F_SLEEP_LO 3
`define OCC_F_CPU_DIV_HI 2
`define OCC_F_CPU_DIV_LO 0
`define OCC_RST_OSC_CTRL0 8'h02
`define OCC_RST_CPU_DIV 3'h2

// ************************************************************
// crystal_oscillator_config fields
// ************************************************************
`define OCC_F_CRYSTAL_LOW_POWER 2
`define OCC_F_CRYSTAL_FLAG_WRITTEN 1
`define OCC_F_CRYSTAL_PRESENT 0
`define OCC_RST_XTAL_CFG 8'h00

// ************************************************************
// system clock config and status fields
// ************************************************************
`define OCC_F_SYSTEM_CLOCK_EXT 2
`define OCC_F_SYSTEM_CLOCK_RANGE_HI 1
`define OCC_F_SYSTEM_CLOCK_RANGE_LO 0
`define OCC_SYSTEM_CLOCK_12M 2'h0
`define OCC_SYSTEM_CLOCK_6M 2'h1
`define OCC_SYSTEM_CLOCK_24M 2'h2
`define OCC_RST_SYSTEM_CLOCK_CFG 8'h00
`define OCC_F_ST_EXT_ACTIVE 0
`define OCC_F_ST_LOCKED 1
`define OCC_F_ST_BLOCKED 2

// ************************************************************
// CPU divider: reload value is divisor minus one
// ************************************************************
`define OCC_CNT_W 8
`define OCC_DIV_CODE_W 3
`define OCC_RELOAD_DIV8 8'h07
`define OCC_RELOAD_DIV4 8'h03
`define OCC_RELOAD_DIV2 8'h01
`define OCC_RELOAD_DIV1 8'h00
`define OCC_RELOAD_DIV16 8'h0F
`define OCC_RELOAD_DIV32 8'h1F
`define OCC_RELOAD_DIV128 8'h7F
`define OCC_RELOAD_DIV256 8'hFF

`endif

// >>> occ_sync2.v
/*
 * Two-flop synchroniser for the two 32 kHz oscillator levels.
 * Assumes the inputs are slow levels from outside the system clock.
 */
`default_nettype none
`include "occ_consts.vh"

module occ_sync2 (
    input wire clock,
    input wire rstn,
    input wire [1:0] async_in,
    output wire [1:0] sync_out
);

    reg [1:0] stage_a;
    reg [1:0] stage_b;
    genvar i;

    generate
        for (i = 0; i < 2; i = i + 1) begin : g_bit
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    stage_a[i] <= 1'b0;
                    stage_b[i] <= 1'b0;
                end else begin
                    stage_a[i] <= async_in[i];
                    stage_b[i] <= stage_a[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage_b;

endmodule // occ_sync2

`default_nettype wire

// >>> occ_cpu_div.v
/*
 * CPU clock divider: one-cycle tick every N system clocks, N chosen
 * by a three-bit code. Assumes it runs on the system clock, which is
 * the same clock whether internal or external.
 */
`default_nettype none
`include "occ_consts.vh"

module occ_cpu_div (
    input wire clock,
    input wire rstn,
    input wire [`OCC_DIV_CODE_W-1:0] code,
    output reg tick
);

    reg [`OCC_CNT_W-1:0] count;
    reg [`OCC_CNT_W-1:0] reload;
    reg [`OCC_DIV_CODE_W-1:0] last_code;

    always @* begin
        case (code)
            3'h0: reload = `OCC_RELOAD_DIV8;
            3'h1: reload = `OCC_RELOAD_DIV4;
            3'h2: reload = `OCC_RELOAD_DIV2;
            3'h3: reload = `OCC_RELOAD_DIV1;
            3'h4: reload = `OCC_RELOAD_DIV16;
            3'h5: reload = `OCC_RELOAD_DIV32;
            3'h6: reload = `OCC_RELOAD_DIV128;
            default: reload = `OCC_RELOAD_DIV256;
        endcase
    end

    // A code change restarts the count so no stretched period appears
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count <= {`OCC_CNT_W{1'b0}};
            last_code <= `OCC_RST_CPU_DIV;
            tick <= 1'b0;
        end else if (code != last_code) begin
            last_code <= code;
            count <= reload;
            tick <= 1'b0;
        end else if (count == {`OCC_CNT_W{1'b0}}) begin
            count <= reload;
            tick <= 1'b1;
        end else begin
            count <= count - 8'h01;
            tick <= 1'b0;
        end
    end

endmodule // occ_cpu_div

`default_nettype wire

// >>> occ_osc_clock_config_assertions.sv
/* Checker for the oscillator clock configuration registers.
   Assumes it is bound to occ_osc_clock_config and sees only its ports. */
`default_nettype none
`include "occ_consts.vh"
module occ_chk (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`OCC_ADR_W-1:0] wb_adr_i,
    input wire logic [`OCC_SEL_W-1:0] wb_sel_i,
    input wire logic [`OCC_DAT_W-1:0] wb_dat_i,
    input wire logic [`OCC_DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic ext_32k_select,
    input wire logic bandgap_keep_on,
    input wire logic bandgap_buzz_disable,
    input wire logic [1:0] sleep_interval,
    input wire logic cpu_clock_tick,
    input wire logic crystal_low_power,
    input wire logic crystal_present
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ************************************************************
    // Shadow of write traffic
    // ************************************************************
    logic locked;
    logic [2:0] div_code;
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_ok = take && wb_we_i && wb_sel_i[0];
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            locked <= 1'b0;
            div_code <= 3'h2;
        end else if (wr_ok) begin
            if (wb_adr_i == 10'h384)
                locked <= 1'b1;
            if (wb_adr_i == 10'h380)
                div_code <= wb_dat_i[2:0];
        end
    end
    sequence wr_ctrl0;
        wr_ok && wb_adr_i == 10'h380;
    endsequence
    // Ticks from the old code may linger until the divider sees a change
    sequence code_held;
        $stable(div_code) [*5];
    endsequence
    // ************************************************************
    // Assertions
    // ************************************************************
    AST_ACK_ONE:
    assert property (take |=> wb_ack_o) else $error("no ack after request");
    AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_ACK_IDLE:
    assert property (!wb_cyc_i |=> !wb_ack_o) else $error("stray ack");
    AST_DAT_HIGH:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    AST_CTRL0_OUT:
    assert property (wr_ctrl0 |-> ##2
        (sleep_interval == $past(wb_dat_i[4:3], 2) &&
         bandgap_keep_on == $past(wb_dat_i[5], 2) &&
         bandgap_buzz_disable ==
         ($past(wb_dat_i[6], 2) && !$past(wb_dat_i[5], 2))))
        else $error("control outputs do not follow write");
    AST_KEEP_PRIO:
    assert property (bandgap_keep_on |-> !bandgap_buzz_disable)
        else $error("buzz disable active with keep on");
    AST_EXT_GATED:
    assert property (ext_32k_select |-> crystal_present)
        else $error("crystal selected while absent");
    AST_LOCK:
    // The output lags the register by one clock, so the first write's own
    // update is still allowed one cycle after the lock is seen
    assert property (locked && $past(locked, 2) |->
        $stable(crystal_present) && $stable(crystal_low_power))
        else $error("crystal config changed after lock");
    AST_TICK_GAP:
    assert property (code_held ##0 (div_code != 3'h3 && cpu_clock_tick)
        |=> !cpu_clock_tick) else $error("ticks too close");
endmodule // occ_chk
bind occ_osc_clock_config occ_chk occ_chk_inst (.clock, .rstn,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .ext_32k_select, .bandgap_keep_on,
    .bandgap_buzz_disable, .sleep_interval, .cpu_clock_tick,
    .crystal_low_power, .crystal_present);
`default_nettype wire

// >>> occ_tb.sv
/* Self-checking bench for the oscillator clock configuration registers.
   Assumes the design files and the checker are compiled before it. */
`default_nettype none
`include "occ_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic osc_int_32k = 1'b0;
    logic osc_ext_32k = 1'b0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, clk_32k, ext_32k_select, bandgap_keep_on;
    wire bandgap_buzz_disable, cpu_clock_tick, crystal_low_power;
    wire crystal_present, system_clock_external;
    wire [1:0] sleep_interval, system_clock_range;
    int error_cnt = 0;
    int n_compared = 0;
    int m_ctrl0, m_xtal, m_sys;
    logic [3:0] m_sel = 4'hF;
    int divs[8] = '{8, 4, 2, 1, 16, 32, 128, 256};
    occ_osc_clock_config occ_osc_clock_config_inst (.clock, .rstn,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .osc_int_32k, .osc_ext_32k, .clk_32k,
        .ext_32k_select, .bandgap_keep_on, .bandgap_buzz_disable,
        .sleep_interval, .cpu_clock_tick, .crystal_low_power,
        .crystal_present, .system_clock_range, .system_clock_external);
    initial forever #5 clock = ~clock;
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    function automatic logic [31:0] model_rd(input logic [9:0] adr);
        case (adr)
        10'h380: return m_ctrl0;
        10'h384: return m_xtal;
        10'h3C0: return m_sys;
        10'h3C4: return {m_ctrl0[7] & ~m_xtal[0], m_xtal[1],
                         m_ctrl0[7] & m_xtal[0]};
        default: return 0;
        endcase
    endfunction
    task automatic bus(input logic we, input logic [9:0] adr,
                       input logic [7:0] d, output logic [31:0] q);
        int i;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= m_sel;
        wb_dat_i <= {24'h000000, d};
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (i >= 20) begin
            error_cnt++;
            $display("BAD %0t no bus answer", $time);
            print_verdict();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (we && m_sel[0]) begin
            case (adr)
            10'h380: m_ctrl0 = d;
            10'h384: if (!m_xtal[1]) m_xtal = (d & 8'h05) | 8'h02;
            10'h3C0: m_sys = d & 8'h07;
            default: ;
            endcase
        end
    endtask
    task automatic wr(input logic [9:0] adr, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, adr, d, q);
    endtask
    task automatic chk_rd(input logic [9:0] adr);
        logic [31:0] q;
        bus(1'b0, adr, 8'h00, q);
        cmp(q, model_rd(adr), "read");
    endtask
    task automatic chk_outs();
        @(posedge clock);
        cmp(ext_32k_select, m_ctrl0[7] & m_xtal[0], "sel");
        cmp(bandgap_keep_on, m_ctrl0[5], "keep");
        cmp(bandgap_buzz_disable, m_ctrl0[6] & ~m_ctrl0[5],
            "buzz");
        cmp(sleep_interval, m_ctrl0[4:3], "sleep");
        cmp(crystal_low_power, m_xtal[2], "lpm");
        cmp(crystal_present, m_xtal[0], "present");
        // Range code 3 is not valid and shows as 12 MHz
        cmp(system_clock_range, m_sys[1:0] % 3, "range");
        cmp(system_clock_external, m_sys[2], "external_clock_input");
    endtask
    task automatic chk_32k();
        int j;
        for (j = 0; j < 2; j++) begin
            osc_int_32k <= j[0];
            osc_ext_32k <= !j[0];
            repeat (5) @(posedge clock);
            cmp(clk_32k, (m_ctrl0[7] & m_xtal[0]) ^ j[0], "32k");
        end
    endtask
    // Restart after a code change is skipped before timing a full gap
    task automatic chk_div(input int code);
        int i;
        int gap;
        wr(10'h380, code[7:0]);
        repeat (3) @(posedge clock);
        for (i = 0; i < 600 && cpu_clock_tick !== 1'b1; i++)
            @(posedge clock);
        gap = 0;
        do begin
            @(posedge clock);
            gap++;
        end while (cpu_clock_tick !== 1'b1 && gap < 600);
        if (i >= 600 || gap >= 600) begin
            error_cnt++;
            $display("BAD %0t no divider tick", $time);
            print_verdict();
        end
        cmp(gap, divs[code], "divider");
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin : main
        int i;
        void'($urandom(19));
        m_ctrl0 = 2;
        m_xtal = 0;
        m_sys = 0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        chk_rd(10'h380);
        chk_rd(10'h384);
        chk_outs();
        wr(10'h3FC, 8'hFF);
        chk_rd(10'h3FC);
        wr(10'h381, 8'hFF);
        chk_rd(10'h381);
        m_sel = 4'hE;
        wr(10'h380, 8'hFF);
        m_sel = 4'hF;
        chk_rd(10'h380);
        for (i = 0; i < 8; i++) begin
            wr(10'h380, ($urandom & 8'h1F) | (i << 5));
            chk_outs();
            chk_rd(10'h3C4);
            chk_32k();
        end
        for (i = 0; i < 8; i++)
            chk_div(i);
        for (i = 0; i < 5; i++) begin
            wr(10'h3C0, (i == 4) ? 8'h07 : (i == 3) ? 8'h04 : i[7:0]);
            chk_outs();
            chk_rd(10'h3C0);
        end
        wr(10'h3C0, 8'h02);
        chk_div(3);
        wr(10'h384, 8'h05);
        chk_rd(10'h384);
        wr(10'h380, 8'h80);
        chk_outs();
        chk_32k();
        chk_rd(10'h3C4);
        wr(10'h380, 8'h00);
        chk_outs();
        wr(10'h384, 8'h00);
        chk_rd(10'h384);
        chk_outs();
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        m_ctrl0 = 2;
        m_xtal = 0;
        m_sys = 0;
        chk_rd(10'h384);
        wr(10'h384, 8'h04);
        chk_rd(10'h384);
        wr(10'h380, 8'h80);
        chk_outs();
        chk_rd(10'h3C4);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
